// ==== common/stage_cmd_pkg.sv ====
// Purpose: shared constants and types for the stage command selector port
// Assumes: 100 MHz sys_clk
// Notes:   word layout is fixed by the selector units
`default_nettype none
package stage_cmd_pkg;

  localparam int unsigned WORD_W      = 15;
  localparam int unsigned ADDR_W      = 5;
  localparam int unsigned CMD_W       = 8;
  localparam int unsigned CMD_LSB     = 0;
  localparam int unsigned ADDR_LSB    = 8;
  localparam int unsigned READ_BIT    = 13;
  localparam int unsigned RESET_BIT   = 14;
  localparam logic [14:0] SEL_RESET_VAL = 15'h0000;

  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned SETTLE_MS      = 18;
  localparam int unsigned FIRE_HOLD_MS   = 25;
  localparam int unsigned SETTLE_CYCLES  = (SETTLE_MS * 1000000 + CLK_PERIOD_NS - 1)
                                           / CLK_PERIOD_NS;
  localparam int unsigned FIRE_CYCLES    = (FIRE_HOLD_MS * 1000000 + CLK_PERIOD_NS - 1)
                                           / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W        = 22;

  typedef struct packed {
    logic       reset_cmd;
    logic       read_cmd;
    logic [4:0] stage_addr;
    logic [7:0] command;
  } selector_word_t;

  typedef struct packed {
    logic           valid;
    logic           is_read;
    selector_word_t data;
  } pio_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] feedback;
  } pio_resp_t;

endpackage
`default_nettype wire

// ==== src/settle_timer.sv ====
// Purpose: selector settle timer, counts cycles after each register load
// Assumes: restart is a one-cycle pulse from the same clock domain
// Notes:   elapsed saturates so it never wraps back under a limit
`timescale 1ns/1ps
`default_nettype none
module settle_timer
  import stage_cmd_pkg::*;
#(
  parameter int unsigned W = TIMER_W
)(
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  input  wire logic         restart,
  output var  logic [W-1:0] count
);

  typedef struct packed
  {
    logic [W-1:0] cnt;
  } timer_state_t;

  timer_state_t state_reg;
  timer_state_t state_next;

  always_comb
  begin
    state_next = state_reg;
    if (restart)
      state_next.cnt = '0;
    else if (state_reg.cnt != {W{1'b1}})
      state_next.cnt = state_reg.cnt + 1'b1;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign count = state_reg.cnt;

  restart_zero_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    restart |=> count == '0)
    else $error("timer did not restart");

endmodule // settle_timer
`default_nettype wire

// ==== src/stage_command_selector_port.sv ====
// Purpose: selector command register with complement feedback read-back
// Assumes: pins from the selector units are asynchronous to sys_clk
// Notes:   the sequence itself is run by software; this block holds and reports
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - command word is 15 bits: 5 address, 8 command, read and reset
// - whole register drives every selector unit in parallel at once
// - five address lines, one per selector unit
// - register loads from a program I/O write of 15 bits
// - at least 18 ms after a load before feedback is read (not enforced: a read is served at once, settle_done only reports the wait)
// - feedback read returns the eight returned complement bits to the computer
// - data moves only on a program I/O transfer; result held until asked
module stage_command_selector_port
  import stage_cmd_pkg::*;
#(
  parameter int unsigned SETTLE_CNT = SETTLE_CYCLES,
  parameter int unsigned FIRE_CNT   = FIRE_CYCLES
)(
  input  wire logic           sys_clk,
  input  wire logic           reset_n,
  input  wire pio_req_t       program_io_transfer,
  input  wire logic [7:0]     feedback_pins,
  output var  pio_resp_t      pio_resp,
  output var  selector_word_t selector_out,
  output var  logic           settle_done,
  output var  logic           fire_held
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed
  {
    selector_word_t sel;
    logic [7:0]     fb_meta;
    logic [7:0]     fb_sync;
    pio_resp_t      resp;
    logic           settled;
    logic           fired;
  } port_state_t;

  port_state_t          state_reg;
  port_state_t          state_next;
  logic [TIMER_W-1:0]   elapsed;
  logic                 load_pulse;
  logic                 read_pulse;

  assign load_pulse = program_io_transfer.valid && !program_io_transfer.is_read;
  assign read_pulse = program_io_transfer.valid && program_io_transfer.is_read;

  // one counter serves both waits; any write restarts it
  settle_timer #(.W(TIMER_W)) timer_u
  (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .restart (load_pulse),
    .count   (elapsed)
  );

  // ****************************************
  // helpers
  // ****************************************
  // flag registers add one cycle, so compare against limit minus one
  function automatic logic reached(input logic [TIMER_W-1:0] cnt,
                                   input int unsigned        limit);
    return cnt >= TIMER_W'(limit - 1);
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    state_next         = state_reg;
    // two flops: the units' pins are not timed to sys_clk
    state_next.fb_meta = feedback_pins;
    state_next.fb_sync = state_reg.fb_meta;
    state_next.resp.valid = 1'b0;
    if (load_pulse)
    begin
      state_next.sel = program_io_transfer.data;
    end
    if (read_pulse)
    begin
      // bits come back as the units drive them, already complemented
      state_next.resp.valid    = 1'b1;
      state_next.resp.feedback = state_reg.fb_sync;
    end
    // status only; the 18 ms wait itself is software's to honour
    state_next.settled = !load_pulse && reached(elapsed, SETTLE_CNT);
    state_next.fired   = !load_pulse && state_reg.sel.read_cmd
                         && reached(elapsed, FIRE_CNT);
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg     <= '0;
      state_reg.sel <= SEL_RESET_VAL;
    end
    else
      state_reg <= state_next;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign selector_out = state_reg.sel;
  assign pio_resp     = state_reg.resp;
  assign settle_done  = state_reg.settled;
  assign fire_held    = state_reg.fired;

  // ****************************************
  // checks
  // ****************************************
  reg_load_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    load_pulse |=> selector_out == $past(program_io_transfer.data))
    else $error("register not loaded from write");

  reg_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !load_pulse |=> $stable(selector_out))
    else $error("register changed without a write");

  read_resp_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (program_io_transfer.valid && program_io_transfer.is_read) |=>
      pio_resp.valid && pio_resp.feedback == $past(state_reg.fb_sync))
    else $error("feedback read wrong");

  resp_only_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !(program_io_transfer.valid && program_io_transfer.is_read) |=> !pio_resp.valid)
    else $error("response without a read");

  settle_clear_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    load_pulse |=> !settle_done [*2])
    else $error("settle flag too early");

  settle_time_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    settle_done |-> elapsed >= TIMER_W'(SETTLE_CNT))
    else $error("settle flag before minimum");

  fire_time_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    fire_held |-> selector_out.read_cmd && elapsed >= TIMER_W'(FIRE_CNT))
    else $error("fire hold flag wrong");

  fanout_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    load_pulse |=> selector_out[RESET_BIT] == $past(program_io_transfer.data.reset_cmd)
                   && selector_out[READ_BIT] == $past(program_io_transfer.data.read_cmd))
    else $error("control bits not sent to the units");

  layout_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    load_pulse |=> selector_out[ADDR_LSB +: ADDR_W] == $past(program_io_transfer.data.stage_addr)
                   && selector_out[CMD_LSB +: CMD_W] == $past(program_io_transfer.data.command))
    else $error("word fields out of place");

  read_keep_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    read_pulse |=> selector_out == $past(selector_out))
    else $error("register disturbed by a read");

  // a result is held for software, so it may be read late or twice
  resp_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !read_pulse |=> $stable(pio_resp.feedback))
    else $error("feedback changed without a read");

  sync_depth_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    pio_resp.valid |-> pio_resp.feedback == $past(state_reg.fb_meta, 2))
    else $error("feedback not taken through two flops");

  meta_in_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    1'b1 |=> state_reg.fb_meta == $past(feedback_pins))
    else $error("feedback pins not captured");

  // ****************************************
  // checks: timers
  // ****************************************
  // each flag rises at one timer count and falls only on a write
  settle_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    settle_done && !load_pulse |=> settle_done)
    else $error("settle flag dropped without a write");

  settle_rise_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !load_pulse && elapsed == TIMER_W'(SETTLE_CNT - 1) |=> settle_done)
    else $error("settle flag late");

  fire_clear_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    load_pulse |=> !fire_held)
    else $error("fire hold flag survived a write");

  fire_rise_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !load_pulse && selector_out.read_cmd && elapsed == TIMER_W'(FIRE_CNT - 1)
      |=> fire_held)
    else $error("fire hold flag late");

  fire_need_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !selector_out.read_cmd |=> !fire_held)
    else $error("fire hold flag without read bit");

  fire_keep_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    fire_held && !load_pulse |=> fire_held)
    else $error("fire hold flag dropped without a write");

  load_cov_c:   cover property (@(posedge sys_clk) load_pulse);
  read_cov_c:   cover property (@(posedge sys_clk) pio_resp.valid);
  settle_cov_c: cover property (@(posedge sys_clk) settle_done);
  fire_cov_c:   cover property (@(posedge sys_clk) fire_held);
  retry_cov_c:  cover property (@(posedge sys_clk) load_pulse && program_io_transfer.data.reset_cmd);

endmodule // stage_command_selector_port
`default_nettype wire

// ==== dv/selector_units.sv ====
// Purpose: far-side selector units echoing the command word
// Assumes: the port word is stable while a unit is addressed
// Notes:   bad flips the echo to force the retry path
`timescale 1ns/1ps
`default_nettype none
module selector_units
  import stage_cmd_pkg::*;
(
  input  wire logic           sys_clk,
  input  wire selector_word_t word,
  input  wire logic           bad,
  output var  logic [7:0]     pins
);
  // ****************
  // echo
  // ****************
  // unaddressed pins wander so a stale value never looks valid
  logic [7:0] idle_reg = 8'h5a;
  always @(posedge sys_clk) idle_reg <= ~idle_reg;
  // a complemented retry code decodes as the same operation
  always_comb pins = $onehot(word.stage_addr) ? ~word.command ^ {8{bad}} : idle_reg;
endmodule // selector_units
`default_nettype wire

// ==== dv/stage_command_selector_port_bench.sv ====
// Purpose: self-checking bench for the selector command port
// Assumes: short settle and fire counts stand in for the millisecond ones
// Notes:   feedback results are checked by a separate watcher
`timescale 1ns/1ps
`default_nettype none
module stage_command_selector_port_bench;
  import stage_cmd_pkg::*;
  localparam int unsigned SC = 20;
  localparam int unsigned FC = 30;
  logic           sys_clk = 0;
  logic           reset_n = 0;
  pio_req_t       req = '0;
  logic           bad = 0;
  logic [7:0]     pins;
  pio_resp_t      resp;
  selector_word_t sel;
  logic           settle_done;
  logic           fire_held;
  int             fails = 0;
  int             n_compared = 0;
  int             seed = 95;
  int             n;
  logic [7:0]     cmd;
  logic [7:0]     exp_q[$];
  selector_word_t last_w = SEL_RESET_VAL;
  always #5 sys_clk = ~sys_clk;
  stage_command_selector_port #(.SETTLE_CNT(SC), .FIRE_CNT(FC)) DUT (.sys_clk(sys_clk),
    .reset_n(reset_n), .program_io_transfer(req), .feedback_pins(pins), .pio_resp(resp),
    .selector_out(sel), .settle_done(settle_done), .fire_held(fire_held));
  selector_units units (.sys_clk(sys_clk), .word(sel), .bad(bad), .pins(pins));
  // ****************
  // tasks
  // ****************
  task automatic chk(string what, logic [14:0] seen, logic [14:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  function automatic selector_word_t mk(logic rs, logic rd, logic [4:0] a, logic [7:0] c);
    return {rs, rd, a, c};
  endfunction
  task automatic put(logic rd, selector_word_t w);
    @(posedge sys_clk);
    #1;
    req = '{valid: 1'b1, is_read: rd, data: w};
    @(posedge sys_clk);
    #1;
    req.valid = 1'b0;
    if (!rd)
    begin
      chk("selector_out", sel, w);
      last_w = w;
    end
  endtask
  task automatic await(input logic fire, output int k);
    k = 0;
    while ((fire ? fire_held : settle_done) !== 1'b1 && k < 4 * FC)
    begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    if (k == 4 * FC)
    begin
      fails++;
      give_verdict();
    end
  endtask
  // ****************
  // watcher
  // ****************
  always @(negedge sys_clk)
    if (resp.valid === 1'b1)
      chk("feedback", resp.feedback, exp_q.size() ? exp_q.pop_front() : 8'hxx);
  // ****************
  // sequence
  // ****************
  initial
  begin
    repeat (2) @(posedge sys_clk);
    #1;
    reset_n = 1;
    chk("reset word", sel, SEL_RESET_VAL);
    for (int i = 0; i < 5; i++)
    begin
      cmd = 8'($random(seed));
      bad = i[0];
      chk("hung stage", sel, last_w);
      put(0, mk(0, 0, 5'h01 << i, cmd));
      chk("settle early", settle_done, 0);
      await(0, n);
      chk("settle time", n[14:0], SC);
      exp_q.push_back(~cmd ^ {8{bad}});
      put(1, mk(0, 0, 5'h01 << i, cmd));
      if (bad)
      begin
        put(0, 15'h4000);
        await(0, n);
        put(0, mk(0, 0, 5'h01 << i, ~cmd));
        bad = 0;
        await(0, n);
        exp_q.push_back(cmd);
        put(1, mk(0, 0, 5'h01 << i, ~cmd));
      end
      put(0, mk(0, 1, 5'h01 << i, 8'h00));
      await(1, n);
      chk("fire time", n[14:0], FC);
    end
    repeat (4) @(posedge sys_clk);
    chk("reads left", exp_q.size(), 0);
    give_verdict();
  end
endmodule // stage_command_selector_port_bench
`default_nettype wire
